// ### ism_sequencer.sv
`timescale 1ns/1ps
// Operation
// - New request clears flags, then checks parameters
// - Bad parameter: set error, answer, no bus
// - Occupied bus: answer busy, no start
// - Free bus: ready, in-progress, send start
// - One event for start done, stop seen
// - After start, enable byte events, send address
// - Address byte is address then direction bit
// - Status: progress, param, nack, address bits
// - Byte done at ninth clock falling edge
// - Address nack sets mismatch flag, ends transfer
// - Read: ack earlier bytes, nack final byte
// - Stop seen restores setup, clears in-progress
module ism_sequencer #(
  parameter int QTR_CYC = ism_pkg::QTR_CYC
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Request and answer
  input  wire logic       req_valid,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_dir,
  input  wire logic [7:0] req_len,
  output logic            resp_valid,
  output logic [1:0]      resp_code,
  // Data stream
  input  wire logic [7:0] tx_data,
  output logic            tx_take,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  // Status and events
  output logic [7:0]      status,
  output logic            start_stop_evt,
  output logic            byte_done_evt,
  // Open-drain bus pins
  input  wire logic       bus_clock_pin_i,
  output logic            bus_clock_pin_o,
  output logic            bus_clock_pin_oe,
  input  wire logic       bus_data_pin_i,
  output logic            bus_data_pin_o,
  output logic            bus_data_pin_oe
);
  ism_bit_if bif ();

  ism_pkg::ism_state_t st_q, st_d;
  logic [1:0] scl_m_q, sda_m_q;
  logic       scl_p_q, sda_p_q;
  logic       busy_q, busy_d;
  logic       inprog_q, inprog_d, parerr_q, parerr_d;
  logic       nackerr_q, nackerr_d, addrerr_q, addrerr_d;
  logic       byte_en_q, byte_en_d, write_q, write_d;
  logic [7:0] cnt_q, cnt_d, rxd_q, rxd_d;
  logic       rxv_q, rxv_d, take_q, take_d, rv_q, rv_d, sse_q, sse_d;
  logic       bde_q, bde_d;
  logic [1:0] rc_q, rc_d;
  logic       cv_q, cv_d, ack_q, ack_d;
  logic [1:0] cmd_q, cmd_d;
  logic [7:0] txb_q, txb_d;
  logic       par_ok, stop_seen, start_seen;

  // Pins pass two flops before anything reads them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_m_q <= 2'b11; sda_m_q <= 2'b11; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= {scl_m_q[0], bus_clock_pin_i};
      sda_m_q <= {sda_m_q[0], bus_data_pin_i};
      scl_p_q <= scl_m_q[1];
      sda_p_q <= sda_m_q[1];
    end
  end
  assign bif.scl_s = scl_m_q[1];
  assign bif.sda_s = sda_m_q[1];
  assign stop_seen  = scl_m_q[1] && scl_p_q && sda_m_q[1] && !sda_p_q;
  assign start_seen = scl_m_q[1] && scl_p_q && !sda_m_q[1] && sda_p_q;

  assign par_ok = (req_addr <= ism_pkg::ADDR_MAX) &&
                  (req_dir == ism_pkg::DIR_WRITE ||
                   req_dir == ism_pkg::DIR_READ) &&
                  (req_len >= ism_pkg::LEN_MIN);

  always_comb
  begin
    st_d = st_q; busy_d = busy_q; inprog_d = inprog_q;
    parerr_d = parerr_q; nackerr_d = nackerr_q; addrerr_d = addrerr_q;
    byte_en_d = byte_en_q; write_d = write_q; cnt_d = cnt_q;
    rxd_d = rxd_q; rxv_d = 1'b0; take_d = 1'b0; rv_d = 1'b0;
    rc_d = rc_q; sse_d = 1'b0; bde_d = 1'b0; cv_d = 1'b0;
    cmd_d = cmd_q; ack_d = ack_q; txb_d = txb_q;
    if (start_seen)
      busy_d = 1'b1;
    if (stop_seen)
    begin
      busy_d    = 1'b0;
      sse_d     = 1'b1;
      inprog_d  = 1'b0;
      byte_en_d = 1'b0;
    end
    // Only byte commands count; a stop may end before it is seen on pins
    if (bif.done && byte_en_q &&
        (st_q == ism_pkg::S_ADDR || st_q == ism_pkg::S_DATA))
      bde_d = 1'b1;
    case (st_q)
      ism_pkg::S_IDLE:
        if (req_valid)
        begin
          // Clearing comes first; flags set here win afterwards
          inprog_d = 1'b0; parerr_d = 1'b0;
          nackerr_d = 1'b0; addrerr_d = 1'b0;
          rv_d = 1'b1;
          if (!par_ok)
          begin
            parerr_d = 1'b1;
            rc_d     = ism_pkg::RES_PARERR;
          end
          else if (busy_q)
            rc_d = ism_pkg::RES_BUSY;
          else
          begin
            rc_d     = ism_pkg::RES_RDY;
            inprog_d = 1'b1;
            cv_d     = 1'b1;
            cmd_d    = ism_pkg::CMD_START;
            write_d  = (req_dir == ism_pkg::DIR_WRITE);
            cnt_d    = req_len;
            txb_d    = {req_addr[6:0], req_dir[0]};
            st_d     = ism_pkg::S_START;
          end
        end
      ism_pkg::S_START:
        if (bif.done)
        begin
          sse_d     = 1'b1;
          byte_en_d = 1'b1;
          cv_d      = 1'b1;
          cmd_d     = ism_pkg::CMD_BYTE;
          ack_d     = 1'b1;
          st_d      = ism_pkg::S_ADDR;
        end
      ism_pkg::S_ADDR, ism_pkg::S_DATA:
        if (bif.done)
        begin
          cv_d = 1'b1;
          if (st_q == ism_pkg::S_DATA && !write_q)
          begin
            rxd_d = bif.rx_byte;
            rxv_d = 1'b1;
            cnt_d = cnt_q - 8'h01;
          end
          if (st_q == ism_pkg::S_DATA && write_q && !bif.nack_in)
            cnt_d = cnt_q - 8'h01;
          if (st_q == ism_pkg::S_ADDR && bif.nack_in)
          begin
            addrerr_d = 1'b1;
            cmd_d     = ism_pkg::CMD_STOP;
            st_d      = ism_pkg::S_STOP;
          end
          else if (write_q && st_q == ism_pkg::S_DATA && bif.nack_in)
          begin
            nackerr_d = 1'b1;
            cmd_d     = ism_pkg::CMD_STOP;
            st_d      = ism_pkg::S_STOP;
          end
          else if (st_q == ism_pkg::S_DATA && cnt_q == 8'h01)
          begin
            cmd_d = ism_pkg::CMD_STOP;
            st_d  = ism_pkg::S_STOP;
          end
          else
          begin
            cmd_d  = ism_pkg::CMD_BYTE;
            st_d   = ism_pkg::S_DATA;
            take_d = write_q;
            txb_d  = write_q ? tx_data : 8'hff;
            // Master acknowledges all but the final read byte
            ack_d  = write_q ||
                     (st_q == ism_pkg::S_ADDR ? cnt_q == 8'h01
                                              : cnt_q == 8'h02);
          end
        end
      ism_pkg::S_STOP:
        if (bif.done)
          st_d = ism_pkg::S_IDLE;
      default: st_d = ism_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= ism_pkg::S_IDLE; busy_q <= 1'b0; inprog_q <= 1'b0;
      parerr_q <= 1'b0; nackerr_q <= 1'b0; addrerr_q <= 1'b0;
      byte_en_q <= 1'b0; write_q <= 1'b0; cnt_q <= 8'h00;
      rxd_q <= 8'h00; rxv_q <= 1'b0; take_q <= 1'b0; rv_q <= 1'b0;
      rc_q <= ism_pkg::RES_RDY; sse_q <= 1'b0; bde_q <= 1'b0;
      cv_q <= 1'b0; cmd_q <= 2'h0; ack_q <= 1'b1; txb_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d; busy_q <= busy_d; inprog_q <= inprog_d;
      parerr_q <= parerr_d; nackerr_q <= nackerr_d;
      addrerr_q <= addrerr_d; byte_en_q <= byte_en_d;
      write_q <= write_d; cnt_q <= cnt_d; rxd_q <= rxd_d;
      rxv_q <= rxv_d; take_q <= take_d; rv_q <= rv_d; rc_q <= rc_d;
      sse_q <= sse_d; bde_q <= bde_d; cv_q <= cv_d; cmd_q <= cmd_d;
      ack_q <= ack_d; txb_q <= txb_d;
    end
  end

  assign bif.cmd_valid = cv_q;
  assign bif.cmd       = cmd_q;
  assign bif.tx_byte   = txb_q;
  assign bif.ack_out   = ack_q;

  ism_bit_engine #(
    .QTR_CYC (QTR_CYC)
  ) u_engine (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (bif)
  );

  assign status = {4'h0, addrerr_q, nackerr_q, parerr_q, inprog_q};
  assign resp_valid       = rv_q;
  assign resp_code        = rc_q;
  assign tx_take          = take_q;
  assign rx_data          = rxd_q;
  assign rx_valid         = rxv_q;
  assign start_stop_evt   = sse_q;
  assign byte_done_evt    = bde_q;
  assign bus_clock_pin_o  = 1'b0;
  assign bus_clock_pin_oe = bif.scl_lo;
  assign bus_data_pin_o   = 1'b0;
  assign bus_data_pin_oe  = bif.sda_lo;

  clear_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_IDLE && req_valid && par_ok
    |=> !status[ism_pkg::ST_NACK] && !status[ism_pkg::ST_ADDR])
    else $error("Flags not cleared on new request");
  par_error_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_IDLE && req_valid && req_addr > 8'h7f
    |=> status[ism_pkg::ST_PARERR] && resp_valid &&
        resp_code == ism_pkg::RES_PARERR && !cv_q)
    else $error("Parameter error not reported");
  busy_reply_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_IDLE && req_valid && par_ok && busy_q
    |=> resp_code == ism_pkg::RES_BUSY && st_q == ism_pkg::S_IDLE)
    else $error("Busy bus not refused");
  ready_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_IDLE && req_valid && par_ok && !busy_q
    |=> status[ism_pkg::ST_INPROG] && cv_q && cmd_q == ism_pkg::CMD_START)
    else $error("Accepted request did not start");
  start_event_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_START && bif.done |=> start_stop_evt ##1 byte_en_q)
    else $error("Start done event missing");
  addr_byte_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_ADDR && $past(st_q) == ism_pkg::S_START
    |-> txb_q[0] == !write_q && cmd_q == ism_pkg::CMD_BYTE)
    else $error("Address byte wrongly formed");
  addr_nack_a: assert property (@(posedge clk_sys) disable iff (rst)
    st_q == ism_pkg::S_ADDR && bif.done && bif.nack_in
    |=> status[ism_pkg::ST_ADDR] && cmd_q == ism_pkg::CMD_STOP)
    else $error("Address nack not handled");
  read_ack_a: assert property (@(posedge clk_sys) disable iff (rst)
    cv_q && cmd_q == ism_pkg::CMD_BYTE && !write_q &&
    st_q == ism_pkg::S_DATA |-> ack_q == (cnt_q == 8'h01))
    else $error("Read acknowledge wrong");
  stop_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    stop_seen |=> !status[ism_pkg::ST_INPROG] && !byte_en_q && start_stop_evt)
    else $error("Stop did not clear progress");
endmodule

// ### ism_pkg.sv
package ism_pkg;
  // Request direction, parameter limits and answer codes
  localparam logic [7:0] DIR_WRITE  = 8'h00;
  localparam logic [7:0] DIR_READ   = 8'h01;
  localparam logic [7:0] ADDR_MAX   = 8'h7f;
  localparam logic [7:0] LEN_MIN    = 8'h01;
  localparam logic [1:0] RES_RDY    = 2'h0;
  localparam logic [1:0] RES_BUSY   = 2'h1;
  localparam logic [1:0] RES_PARERR = 2'h2;
  // Status byte bit positions
  localparam int ST_INPROG = 0;
  localparam int ST_PARERR = 1;
  localparam int ST_NACK   = 2;
  localparam int ST_ADDR   = 3;
  // Engine commands
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_BYTE  = 2'h2;
  localparam logic [1:0] CMD_STOP  = 2'h3;
  // Timing
  localparam int CLK_KHZ       = 100000;
  localparam int BIT_RATE_KBPS = 378;
  localparam int QTR_CYC       = CLK_KHZ / (BIT_RATE_KBPS * 4);
  localparam int LAST_BIT      = 8;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_ADDR  = 3'b011,
    S_DATA  = 3'b010,
    S_STOP  = 3'b110
  } ism_state_t;
  typedef enum logic [1:0] {
    E_IDLE  = 2'b00,
    E_START = 2'b01,
    E_BYTE  = 2'b11,
    E_STOP  = 2'b10
  } ism_eng_t;
endpackage

// ### ism_bit_if.sv
`timescale 1ns/1ps
interface ism_bit_if;
  logic       cmd_valid;
  logic [1:0] cmd;
  logic [7:0] tx_byte;
  logic       ack_out;
  logic       done;
  logic [7:0] rx_byte;
  logic       nack_in;
  logic       scl_s;
  logic       sda_s;
  logic       scl_lo;
  logic       sda_lo;
  modport seq (output cmd_valid, cmd, tx_byte, ack_out, scl_s, sda_s,
               input done, rx_byte, nack_in, scl_lo, sda_lo);
  modport eng (input cmd_valid, cmd, tx_byte, ack_out, scl_s, sda_s,
               output done, rx_byte, nack_in, scl_lo, sda_lo);
endinterface

// ### ism_bit_engine.sv
`timescale 1ns/1ps
module ism_bit_engine #(
  parameter int QTR_CYC = ism_pkg::QTR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  ism_bit_if.eng   bus
);
  ism_pkg::ism_eng_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] sh_q, sh_d;
  logic [7:0] rx_q, rx_d;
  logic       nack_q, nack_d, done_q, done_d;
  logic       scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
  logic       tick, last_ph;

  assign tick    = (cnt_q == 8'(QTR_CYC - 1));
  assign last_ph = (st_q == ism_pkg::E_BYTE) ? (ph_q == 2'h3)
                                             : (ph_q == 2'h2);

  always_comb
  begin
    st_d = st_q; cnt_d = cnt_q; ph_d = ph_q; bit_d = bit_q;
    sh_d = sh_q; rx_d = rx_q; nack_d = nack_q; done_d = 1'b0;
    scl_lo_d = scl_lo_q; sda_lo_d = sda_lo_q;
    if (st_q == ism_pkg::E_IDLE)
    begin
      if (bus.cmd_valid)
      begin
        cnt_d = 8'h00; ph_d = 2'h0; bit_d = 4'h0;
        sh_d  = {bus.tx_byte, bus.ack_out};
        case (bus.cmd)
          ism_pkg::CMD_START: st_d = ism_pkg::E_START;
          ism_pkg::CMD_BYTE:  st_d = ism_pkg::E_BYTE;
          ism_pkg::CMD_STOP:  st_d = ism_pkg::E_STOP;
          default:            st_d = ism_pkg::E_IDLE;
        endcase
      end
    end
    // Slave stretching holds the high phase until the clock is seen high;
    // the release still goes out, or the wait would never end
    else if (st_q == ism_pkg::E_BYTE && ph_q == 2'h1 && !bus.scl_s)
      scl_lo_d = 1'b0;
    else
    begin
      cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
      if (tick)
        ph_d = last_ph ? 2'h0 : ph_q + 2'h1;
      case (st_q)
        ism_pkg::E_START:
        begin
          scl_lo_d = (ph_q == 2'h2);
          sda_lo_d = (ph_q != 2'h0);
        end
        ism_pkg::E_STOP:
        begin
          scl_lo_d = (ph_q == 2'h0);
          sda_lo_d = (ph_q != 2'h2);
        end
        ism_pkg::E_BYTE:
        begin
          scl_lo_d = (ph_q == 2'h0) || (ph_q == 2'h3);
          sda_lo_d = ~sh_q[8];
          if (tick && ph_q == 2'h2)
          begin
            if (bit_q == 4'(ism_pkg::LAST_BIT))
              nack_d = bus.sda_s;
            else
              rx_d = {rx_q[6:0], bus.sda_s};
          end
          if (tick && ph_q == 2'h3)
          begin
            sh_d  = {sh_q[7:0], 1'b1};
            bit_d = bit_q + 4'h1;
          end
        end
        default: st_d = ism_pkg::E_IDLE;
      endcase
      // Byte ends at the falling edge of the ninth clock
      if (tick && last_ph &&
          (st_q != ism_pkg::E_BYTE ||
           bit_q == 4'(ism_pkg::LAST_BIT)))
      begin
        st_d   = ism_pkg::E_IDLE;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q <= ism_pkg::E_IDLE; cnt_q <= 8'h00; ph_q <= 2'h0;
      bit_q <= 4'h0; sh_q <= 9'h1ff; rx_q <= 8'h00; nack_q <= 1'b0;
      done_q <= 1'b0; scl_lo_q <= 1'b0; sda_lo_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; cnt_q <= cnt_d; ph_q <= ph_d; bit_q <= bit_d;
      sh_q <= sh_d; rx_q <= rx_d; nack_q <= nack_d; done_q <= done_d;
      scl_lo_q <= scl_lo_d; sda_lo_q <= sda_lo_d;
    end
  end

  assign bus.done    = done_q;
  assign bus.rx_byte = rx_q;
  assign bus.nack_in = nack_q;
  assign bus.scl_lo  = scl_lo_q;
  assign bus.sda_lo  = sda_lo_q;

  done_scl_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    done_q && $past(st_q) != ism_pkg::E_STOP |-> scl_lo_q)
    else $error("Byte done without clock held low");
endmodule

// ### ism_slave_model.sv
`timescale 1ns/1ps
module ism_slave_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Knobs set by the bench
  input  wire logic [6:0] own_addr,
  input  wire logic [7:0] nack_at,
  input  wire logic [7:0] rd_base,
  input  wire logic [7:0] stretch,
  // Pull-downs and bytes seen
  output logic            scl_oe,
  output logic            sda_oe,
  output logic            got_evt,
  output logic [7:0]      got_byte
);
  logic       scl_q, sda_q, act, adr, rd, mnack, match, drv, ev;
  logic [7:0] sh;
  int         bitc, idx, hold;

  // Sampled on the system clock, so edges show one cycle late
  always @(posedge clk_sys)
  begin
    ev = 1'b0;
    if (hold > 0)
      hold--;
    if (rst)
    begin
      act = 1'b0;
      drv = 1'b0;
      hold = 0;
    end
    else if (scl_q && scl && sda_q && !sda)
    begin
      act = 1'b1;
      adr = 1'b1;
      rd = 1'b0;
      mnack = 1'b0;
      // The start's own clock fall brings the count to zero
      bitc = -1;
    end
    else if (scl_q && scl && !sda_q && sda)
    begin
      act = 1'b0;
      drv = 1'b0;
    end
    else if (act && !scl_q && scl)
    begin
      if (bitc < 8 && (adr || !rd))
        sh = {sh[6:0], sda};
      if (bitc == 8)
        mnack = sda;
    end
    else if (act && scl_q && !scl)
    begin
      bitc++;
      if (bitc == 8)
      begin
        if (adr)
          match = (sh[7:1] == own_addr);
        if (adr)
          rd = sh[0];
        ev = adr || !rd;
        drv = adr ? match : (!rd && idx + 1 != nack_at);
      end
      else if (bitc == 9)
      begin
        bitc = 0;
        hold = stretch;
        idx = adr ? 0 : idx + 1;
        act = !adr || match;
        adr = 1'b0;
        sh = rd_base + idx[7:0];
        drv = act && rd && !mnack && !sh[7];
      end
      else
        drv = act && rd && !adr && !mnack && !sh[7-bitc];
    end
    scl_q = scl;
    sda_q = sda;
    scl_oe <= (hold > 0);
    sda_oe <= drv;
    got_evt <= ev;
    got_byte <= sh;
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((e) !== (g)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_top;
  localparam logic [7:0] SLV = 8'h5a;
  localparam logic [7:0] DW  = ism_pkg::DIR_WRITE;
  localparam logic [7:0] DR  = ism_pkg::DIR_READ;
  localparam logic [1:0] RDY = ism_pkg::RES_RDY;
  localparam logic [1:0] PAR = ism_pkg::RES_PARERR;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        tb_sda_oe = 1'b0;
  logic [7:0]  req_addr = 8'h00, req_dir = 8'h00, req_len = 8'h00;
  logic [7:0]  tx_data = 8'h00, nack_at = 8'h00, rd_base = 8'h00;
  logic [7:0]  stretch = 8'h00, rx_data, status, got_byte, mon_e;
  logic [1:0]  resp_code;
  logic        resp_valid, tx_take, rx_valid, ss_evt, bd_evt, got_evt;
  logic        d_scl_oe, d_sda_oe, s_scl_oe, s_sda_oe, d_scl_o, d_sda_o;
  logic [31:0] seed = 32'hf7ba77d7;
  logic [7:0]  ex_q[$], rx_q[$], tx_q[$];
  int          failures = 0, total_checks = 0, n_ss = 0, n_bd = 0, n;
  int          n_tk = 0;
  wire logic   scl = !(d_scl_oe === 1'b1 || s_scl_oe === 1'b1);
  wire logic   sda = !(d_sda_oe === 1'b1 || s_sda_oe === 1'b1 || tb_sda_oe);

  ism_sequencer #(.QTR_CYC(4)) u_ism_sequencer (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_addr(req_addr), .req_dir(req_dir), .req_len(req_len),
    .resp_valid(resp_valid), .resp_code(resp_code), .tx_data(tx_data),
    .tx_take(tx_take), .rx_data(rx_data), .rx_valid(rx_valid),
    .status(status), .start_stop_evt(ss_evt), .byte_done_evt(bd_evt),
    .bus_clock_pin_i(scl), .bus_clock_pin_o(d_scl_o),
    .bus_clock_pin_oe(d_scl_oe), .bus_data_pin_i(sda),
    .bus_data_pin_o(d_sda_o), .bus_data_pin_oe(d_sda_oe));
  ism_slave_model u_ism_slave_model (
    .clk_sys(clk_sys), .rst(rst), .scl(scl), .sda(sda),
    .own_addr(SLV[6:0]), .nack_at(nack_at), .rd_base(rd_base),
    .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
    .got_evt(got_evt), .got_byte(got_byte));

  initial
    forever #5 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Empty queue gives x, so a surplus byte never matches
  always @(posedge clk_sys)
  begin
    if (ss_evt === 1'b1)
      n_ss++;
    if (bd_evt === 1'b1)
      n_bd++;
    if (tx_take === 1'b1)
      n_tk++;
    if (tx_take === 1'b1 && tx_q.size() > 0)
      tx_data <= tx_q.pop_front();
    if (rx_valid === 1'b1)
    begin
      mon_e = rx_q.size() > 0 ? rx_q.pop_front() : 8'hxx;
      `CHK("rx_data", mon_e, rx_data)
    end
    if (got_evt === 1'b1)
    begin
      mon_e = ex_q.size() > 0 ? ex_q.pop_front() : 8'hxx;
      `CHK("bus_byte", mon_e, got_byte)
    end
  end

  task xfer(input logic [7:0] a, d, l, nk, input logic [1:0] code,
            input logic [7:0] st);
    int         bd0, ss0, nd, k, tk0;
    logic [7:0] base;
    logic       act;
    seed = lfsr_next(seed);
    base = seed[7:0];
    bd0 = n_bd;
    ss0 = n_ss;
    tk0 = n_tk;
    act = 1'b0;
    nd = 0;
    tx_q.delete();
    if (code == RDY && a == SLV)
      nd = (d == DW && nk != 0 && nk < l) ? nk : l;
    if (code == RDY)
      ex_q.push_back({a[6:0], d[0]});
    for (k = 0; k < nd; k++)
    begin
      seed = lfsr_next(seed);
      if (d == DW)
      begin
        ex_q.push_back(seed[7:0]);
        tx_q.push_back(seed[7:0]);
      end
      else
        rx_q.push_back(base + k[7:0]);
    end
    @(posedge clk_sys);
    nack_at <= nk;
    rd_base <= base;
    req_valid <= 1'b1;
    req_addr <= a;
    req_dir <= d;
    req_len <= l;
    if (tx_q.size() > 0)
      tx_data <= tx_q.pop_front();
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    for (k = 0; k < 4 && resp_valid !== 1'b1; k++)
      @(negedge clk_sys);
    `CHK("resp_valid", 1'b1, resp_valid)
    `CHK("resp_code", code, resp_code)
    `CHK("status_take", {6'h00, code == PAR, code == RDY}, status)
    for (k = 0; k < 60000 && status[0] !== 1'b0; k++)
      @(negedge clk_sys);
    // Long enough for the stop to pass both pin synchronisers
    for (k = 0; k < 24; k++)
    begin
      @(negedge clk_sys);
      if (d_scl_oe !== 1'b0 || d_sda_oe !== 1'b0)
        act = 1'b1;
    end
    `CHK("bus_idle", 1'b0, act)
    `CHK("status_end", st, status)
    `CHK("start_stop", code == RDY ? 2 : 0, n_ss - ss0)
    `CHK("byte_evts", code == RDY ? nd + 1 : 0, n_bd - bd0)
    `CHK("queues", 0, ex_q.size() + rx_q.size())
    `CHK("takes", d == DW ? nd : 0, n_tk - tk0)
    `CHK("pin_low", 2'b00, {d_scl_o, d_sda_o})
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(SLV, DW, 8'h03, 8'h00, RDY, 8'h00);
    xfer(SLV, DR, 8'h03, 8'h00, RDY, 8'h00);
    xfer(SLV, DR, 8'h01, 8'h00, RDY, 8'h00);
    xfer(SLV ^ 8'h01, DW, 8'h02, 8'h00, RDY, 8'h08);
    xfer({1'b1, seed[6:0]}, DW, 8'h01, 8'h00, PAR, 8'h02);
    xfer(SLV, 8'h02, 8'h01, 8'h00, PAR, 8'h02);
    xfer(SLV, DW, 8'h00, 8'h00, PAR, 8'h02);
    xfer(SLV, DW, 8'h02, 8'h00, RDY, 8'h00);
    xfer(SLV, DW, 8'h04, 8'h02, RDY, 8'h04);
    // A foreign start holds the bus until its stop
    @(posedge clk_sys);
    tb_sda_oe <= 1'b1;
    repeat (6) @(posedge clk_sys);
    xfer(SLV, DW, 8'h01, 8'h00, ism_pkg::RES_BUSY, 8'h00);
    n = n_ss;
    @(posedge clk_sys);
    tb_sda_oe <= 1'b0;
    stretch <= 8'h0c;
    repeat (12) @(negedge clk_sys);
    `CHK("stop_seen", n + 1, n_ss)
    xfer(SLV, DW, 8'hff, 8'h00, RDY, 8'h00);
    conclude();
  end

  initial
  begin
    repeat (70000) @(posedge clk_sys);
    failures++;
    conclude();
  end
endmodule
